//--- pkg/ppf_pkg.sv
// shared constants and carrier types for the port pin function block
package ppf_pkg;

   // port count and index of each port
   localparam int NPORT = 5;
   localparam int PA = 0;
   localparam int PB = 1;
   localparam int PC = 2;
   localparam int PD = 3;
   localparam int PE = 4;

   // implemented bits per port, listed E, D, C, B, A
   localparam logic [4:0][7:0] PORT_MASK = {8'h1F, 8'hFF, 8'h7F, 8'hFF, 8'hFF};

   // register byte offsets; data and direction banks step by one word per port
   localparam logic [11:0] OFF_DAT = 12'h000;
   localparam logic [11:0] OFF_DIR = 12'h014;
   localparam logic [11:0] OFF_PULL = 12'h028;
   localparam logic [11:0] OFF_KBD = 12'h034;
   localparam logic [11:0] OFF_ADC = 12'h038;
   localparam logic [11:0] OFF_ALT = 12'h03C;
   localparam logic [11:0] OFF_STAT = 12'h040;
   localparam logic [11:0] OFF_MASK = 12'h044;
   localparam logic [11:0] OFF_STEP = 12'h004;

   // pull-up bank slots: ports A, C and D only
   localparam int NPULL = 3;
   localparam logic [2:0][2:0] PULL_PORT = {3'h3, 3'h2, 3'h0};

   // alternate-function control field positions
   localparam int ALT_SPI = 0;
   localparam int ALT_TMR = 4;
   localparam int ALT_SCI = 8;
   localparam int ALT_OSC = 9;
   localparam int ALT_W = 10;

   // status and mask bit positions
   localparam int ST_EXT = 0;
   localparam int ST_KBD = 1;
   localparam int ST_W = 2;

   // reset values of the software registers
   localparam logic [7:0] RST_DAT = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PULL = 8'h00;
   localparam logic [7:0] RST_KBD = 8'h00;
   localparam logic [7:0] RST_ADC = 8'h00;
   localparam logic [9:0] RST_ALT = 10'h000;
   localparam logic [1:0] RST_MASK = 2'h0;

   // one byte per port
   typedef logic [4:0][7:0] ppf_port_t;

   // what the block drives onto the pads
   typedef struct packed {
      ppf_port_t out;   // level when driving
      ppf_port_t oe_n;  // low while the pad is driven
      ppf_port_t pu;    // pull-up engaged
   } ppf_pins_t;

   // requests from the on-chip peripherals for pins they own
   typedef struct packed {
      ppf_port_t out;
      ppf_port_t drive;
   } ppf_alt_t;

   // registered state of the top module, apart from the interrupt toggle and the synchroniser stages
   typedef struct packed {
      ppf_port_t dat;
      ppf_port_t dir;
      logic [2:0][7:0] pull;
      logic [7:0] kbd_en;
      logic [7:0] adc_en;
      logic [9:0] alt;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [7:0] kbd_prev;
      logic tog_prev;
      ppf_pins_t pins;
      ppf_port_t level;
      logic [7:0] kbd_lvl;
      logic rst_out;
      logic rst_oe_n;
      logic startup;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ppf_state_t;

endpackage

//--- src/ppf_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for pad levels and the interrupt toggle
module ppf_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // first stage, read only by the second
   logic [W-1:0] meta;

   // both stages clear to zero; callers invert where idle is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

//--- src/ppf_top.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module ppf_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ppf_pkg::ppf_port_t pin_in,
   output ppf_pkg::ppf_pins_t pin_ctl,
   input wire ppf_pkg::ppf_alt_t alt_req,
   output ppf_pkg::ppf_port_t pin_level,
   output logic [7:0] keypad_wake_input,
   output logic [7:0] analog_channel_input,
   output logic [9:0] alt_grant,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_n,
   input wire logic internal_reset_req,
   output logic startup_reset,
   input wire logic ext_irq_n,
   output logic irq
);

   // state after reset: nothing driven, no pull-ups, pads released
   localparam ppf_pkg::ppf_state_t STATE_RST = '{
      dat: {5{ppf_pkg::RST_DAT}},
      dir: {5{ppf_pkg::RST_DIR}},
      pull: {3{ppf_pkg::RST_PULL}},
      kbd_en: ppf_pkg::RST_KBD,
      adc_en: ppf_pkg::RST_ADC,
      alt: ppf_pkg::RST_ALT,
      stat: 2'h0,
      mask: ppf_pkg::RST_MASK,
      kbd_prev: 8'hFF,
      tog_prev: 1'b0,
      pins: '{out: '0, oe_n: '1, pu: '0},
      level: '0,
      kbd_lvl: 8'h00,
      rst_out: 1'b0,
      rst_oe_n: 1'b1,
      startup: 1'b1,
      irq: 1'b0,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000
   };

   ppf_pkg::ppf_state_t s;       // registered state
   ppf_pkg::ppf_state_t next_s;  // next state
   logic tog;                    // flips on each falling edge of the interrupt pin
   logic [41:0] sync_q;          // synchronised pads, reset pin, toggle
   ppf_pkg::ppf_port_t pin_s;    // synchronised pad levels
   logic rst_pin_s;              // synchronised reset pin, high when released
   logic tog_s;                  // synchronised interrupt toggle

   // address match, used by every register of the map
   function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
      hit = (a == base);
   endfunction

   // pins handed to a peripheral, per port
   function automatic ppf_pkg::ppf_port_t owned(input logic [9:0] alt);
      owned = '0;
      owned[ppf_pkg::PD][3:0] = {4{alt[ppf_pkg::ALT_SPI]}};
      owned[ppf_pkg::PD][7:4] = alt[ppf_pkg::ALT_TMR +: 4];
      owned[ppf_pkg::PE][1:0] = {2{alt[ppf_pkg::ALT_SCI]}};
      owned[ppf_pkg::PE][4:3] = {2{alt[ppf_pkg::ALT_OSC]}};
   endfunction

   // interrupt edge is caught on the pad itself, so it works with pclk
   // stopped; the toggle then crosses into pclk through the synchroniser
   always_ff @(negedge ext_irq_n or negedge presetn) begin
      if (!presetn) begin
         tog <= 1'b0;
      end else begin
         tog <= ~tog;
      end
   end

   // reset pin idles high, so it is inverted around the zero-reset stages
   ppf_sync #(
      .W(42)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({tog, ~reset_pin_in, pin_in}),
      .q(sync_q)
   );

   // unpack the synchronised bundle
   always_comb begin
      pin_s = sync_q[39:0];
      rst_pin_s = ~sync_q[40];
      tog_s = sync_q[41];
   end

   // next-state logic: bus slave, events, pad control
   always_comb begin
      logic [11:0] a;
      logic mapped;
      logic [31:0] rv;
      logic wr;
      logic [1:0] set;
      logic [1:0] clr;
      ppf_pkg::ppf_port_t own;
      ppf_pkg::ppf_port_t view;
      logic drv;
      logic pull_sel;
      a = paddr;
      mapped = 1'b0;
      rv = 32'h0000_0000;
      wr = psel & penable & s.pready & pwrite;
      set = 2'h0;
      clr = 2'h0;
      own = owned(s.alt);
      view = '0;
      drv = 1'b0;
      pull_sel = 1'b0;
      next_s = s;

      // what software sees on a data read: latch for outputs, pad otherwise
      for (int p = 0; p < ppf_pkg::NPORT; p++) begin
         view[p] = (s.dir[p] & s.dat[p]) | (~s.dir[p] & pin_s[p]);
         view[p] = view[p] & ppf_pkg::PORT_MASK[p];
      end
      // analog pins have their digital input cut off from the port b data read; pin_level still passes the pad
      view[ppf_pkg::PB] = view[ppf_pkg::PB] & ~s.adc_en;

      // register read decode
      for (int p = 0; p < ppf_pkg::NPORT; p++) begin
         if (hit(a, ppf_pkg::OFF_DAT + 12'(p) * ppf_pkg::OFF_STEP)) begin
            mapped = 1'b1;
            rv = {24'h000000, view[p]};
         end
         if (hit(a, ppf_pkg::OFF_DIR + 12'(p) * ppf_pkg::OFF_STEP)) begin
            mapped = 1'b1;
            rv = {24'h000000, s.dir[p]};
         end
      end
      for (int k = 0; k < ppf_pkg::NPULL; k++) begin
         if (hit(a, ppf_pkg::OFF_PULL + 12'(k) * ppf_pkg::OFF_STEP)) begin
            mapped = 1'b1;
            rv = {24'h000000, s.pull[k]};
         end
      end
      if (hit(a, ppf_pkg::OFF_KBD)) begin
         mapped = 1'b1;
         rv = {24'h000000, s.kbd_en};
      end
      if (hit(a, ppf_pkg::OFF_ADC)) begin
         mapped = 1'b1;
         rv = {24'h000000, s.adc_en};
      end
      if (hit(a, ppf_pkg::OFF_ALT)) begin
         mapped = 1'b1;
         rv = {22'h0, s.alt};
      end
      if (hit(a, ppf_pkg::OFF_STAT)) begin
         mapped = 1'b1;
         rv = {30'h0, s.stat};
      end
      if (hit(a, ppf_pkg::OFF_MASK)) begin
         mapped = 1'b1;
         rv = {30'h0, s.mask};
      end

      // one wait state: answer lands in flops the cycle after access starts
      next_s.pready = psel & penable & ~s.pready;
      if (psel & penable & ~s.pready) begin
         next_s.prdata = pwrite ? 32'h0000_0000 : rv;
         next_s.pslverr = ~mapped;
      end else if (!psel) begin
         next_s.pslverr = 1'b0;
      end

      // register writes take effect on the completing edge only
      if (wr) begin
         for (int p = 0; p < ppf_pkg::NPORT; p++) begin
            if (hit(a, ppf_pkg::OFF_DAT + 12'(p) * ppf_pkg::OFF_STEP)) begin
               next_s.dat[p] = pwdata[7:0] & ppf_pkg::PORT_MASK[p];
            end
            if (hit(a, ppf_pkg::OFF_DIR + 12'(p) * ppf_pkg::OFF_STEP)) begin
               next_s.dir[p] = pwdata[7:0] & ppf_pkg::PORT_MASK[p];
            end
         end
         for (int k = 0; k < ppf_pkg::NPULL; k++) begin
            if (hit(a, ppf_pkg::OFF_PULL + 12'(k) * ppf_pkg::OFF_STEP)) begin
               // only the bits implemented on the slot's port are stored
               next_s.pull[k] = pwdata[7:0] & ppf_pkg::PORT_MASK[ppf_pkg::PULL_PORT[k]];
            end
         end
         if (hit(a, ppf_pkg::OFF_KBD)) begin
            next_s.kbd_en = pwdata[7:0];
         end
         if (hit(a, ppf_pkg::OFF_ADC)) begin
            next_s.adc_en = pwdata[7:0];
         end
         if (hit(a, ppf_pkg::OFF_ALT)) begin
            next_s.alt = pwdata[9:0];
         end
         if (hit(a, ppf_pkg::OFF_STAT)) begin
            clr = pwdata[1:0];
         end
         if (hit(a, ppf_pkg::OFF_MASK)) begin
            next_s.mask = pwdata[1:0];
         end
      end

      // events: a new toggle value, or a falling keyboard pin
      set[ppf_pkg::ST_EXT] = (tog_s != s.tog_prev);
      set[ppf_pkg::ST_KBD] = |(s.kbd_prev & ~pin_s[ppf_pkg::PA] & s.kbd_en);
      next_s.tog_prev = tog_s;
      next_s.kbd_prev = pin_s[ppf_pkg::PA];

      // sticky flags: a set in the clearing cycle survives
      next_s.stat = (s.stat & ~clr) | set;
      next_s.irq = |(next_s.stat & s.mask);

      // pad control for every implemented bit
      for (int p = 0; p < ppf_pkg::NPORT; p++) begin
         for (int b = 0; b < 8; b++) begin
            pull_sel = 1'b0;
            for (int k = 0; k < ppf_pkg::NPULL; k++) begin
               if (ppf_pkg::PULL_PORT[k] == 3'(p)) begin
                  pull_sel = s.pull[k][b];
               end
            end
            if (own[p][b]) begin
               // owning peripheral sets direction and level
               drv = alt_req.drive[p][b];
               next_s.pins.out[p][b] = alt_req.out[p][b];
            end else if (p == ppf_pkg::PB && s.adc_en[b]) begin
               drv = 1'b0;
               next_s.pins.out[p][b] = 1'b0;
            end else if (p == ppf_pkg::PA && s.kbd_en[b]) begin
               drv = 1'b0;
               next_s.pins.out[p][b] = 1'b0;
            end else begin
               drv = s.dir[p][b];
               next_s.pins.out[p][b] = s.dat[p][b];
            end
            drv = drv & ppf_pkg::PORT_MASK[p][b];
            next_s.pins.oe_n[p][b] = ~drv;
            // pull-up only on a non-driven pin
            next_s.pins.pu[p][b] = pull_sel & ~drv;
         end
      end

      // levels seen by the peripherals
      next_s.level = pin_s;
      next_s.kbd_lvl = pin_s[ppf_pkg::PA] & s.kbd_en;

      // reset pin: pulled low by the block while an internal source asserts
      next_s.rst_out = 1'b0;
      next_s.rst_oe_n = ~internal_reset_req;
      next_s.startup = ~rst_pin_s;

      // a low reset pin returns everything but rst_oe_n, tog_prev and kbd_prev to the startup state
      if (!rst_pin_s) begin
         next_s = STATE_RST;
         next_s.rst_oe_n = ~internal_reset_req;
         next_s.tog_prev = tog_s;
         next_s.kbd_prev = pin_s[ppf_pkg::PA];
      end
   end

   // the state register for s; tog and the synchroniser stages are clocked apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state
   always_comb begin
      prdata = s.prdata;
      pready = s.pready;
      pslverr = s.pslverr;
      pin_ctl = s.pins;
      pin_level = s.level;
      keypad_wake_input = s.kbd_lvl;
      analog_channel_input = s.adc_en;
      alt_grant = s.alt;
      reset_pin_out = s.rst_out;
      reset_pin_oe_n = s.rst_oe_n;
      startup_reset = s.startup;
      irq = s.irq;
   end

endmodule

//--- tb/ppf_board.sv
`timescale 1ns/100ps
// board side: external drivers, pull-ups and floating pads
module ppf_board (
   input wire logic pclk,
   input wire ppf_pkg::ppf_pins_t ctl,
   input wire ppf_pkg::ppf_port_t ext_val,
   input wire ppf_pkg::ppf_port_t ext_en,
   output ppf_pkg::ppf_port_t pad
);
   logic [7:0] flt = 8'hA5; // undriven pads wander, never hold a value
   always @(posedge pclk) flt <= ~flt;
   // device wins where it drives, then the board, then the pull-up
   assign pad = (~ctl.oe_n & ctl.out) | (ctl.oe_n & ext_en & ext_val)
      | (ctl.oe_n & ~ext_en & (ctl.pu | {5{flt}}));
endmodule

//--- tb/ppf_top_properties.sv
`timescale 1ns/100ps
// pad, reset and ownership relations at the block boundary
module ppf_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire ppf_pkg::ppf_pins_t pin_ctl,
   input wire ppf_pkg::ppf_alt_t alt_req,
   input wire logic [9:0] alt_grant,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n,
   input wire logic internal_reset_req,
   input wire logic startup_reset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pad low long enough to cross the synchroniser
   sequence s_pad_low; !reset_pin_in [*3]; endsequence
   // owner and request steady, and no synchronised reset pad low at this edge
   sequence s_own(int b);
      alt_grant[b] && $stable(alt_grant) && $stable(alt_req) && $past(reset_pin_in, 2);
   endsequence
   property p_pu_off; (pin_ctl.pu & ~pin_ctl.oe_n) == '0; endproperty
   property p_pu_port; pin_ctl.pu[1] == 8'h00 && pin_ctl.pu[4] == 8'h00; endproperty
   property p_rst_drv; 1'b1 |=> reset_pin_oe_n == !$past(internal_reset_req); endproperty
   property p_rst_lvl; !reset_pin_oe_n |-> !reset_pin_out; endproperty
   property p_start; s_pad_low |=> startup_reset; endproperty
   property p_start_clr; startup_reset [*2] |=> alt_grant == 10'h000; endproperty
   property p_spi_rel; s_own(0) and !alt_req.drive[3][1] |=> pin_ctl.oe_n[3][1]; endproperty
   property p_tmr_own;
      s_own(4) and alt_req.drive[3][4]
      |=> !pin_ctl.oe_n[3][4] && pin_ctl.out[3][4] == $past(alt_req.out[3][4]);
   endproperty
   property p_sci_own;
      s_own(8) and alt_req.drive[4][0]
      |=> !pin_ctl.oe_n[4][0] && pin_ctl.out[4][0] == $past(alt_req.out[4][0]);
   endproperty
   property p_osc_rel; s_own(9) and !alt_req.drive[4][4] |=> pin_ctl.oe_n[4][4]; endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up on a driven pad");
   a_pu_port: assert property (p_pu_port) else $error("pull-up on port b or e");
   a_rst_drv: assert property (p_rst_drv) else $error("reset pad drive wrong");
   a_rst_lvl: assert property (p_rst_lvl) else $error("reset pad driven high");
   a_start: assert property (p_start) else $error("no startup on low pad");
   a_start_clr: assert property (p_start_clr) else $error("owner kept in startup");
   a_spi_rel: assert property (p_spi_rel) else $error("spi pin not released");
   a_tmr_own: assert property (p_tmr_own) else $error("timer pin not driven");
   a_sci_own: assert property (p_sci_own) else $error("sci pin not driven");
   a_osc_rel: assert property (p_osc_rel) else $error("osc pin not released");
endmodule

//--- tb/ppf_top_tb.sv
`timescale 1ns/100ps
// bench: register model, board model and pin expectations
module ppf_top_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, err, rst_out, rst_oe_n, startup, irq, reset_pad;
   logic int_req = 1'b0, ext_irq_n = 1'b1, rst_low = 1'b0; // board side levels
   ppf_pkg::ppf_port_t pad, lvl, ext_val = '0, ext_en = '1; // board drives free pads
   ppf_pkg::ppf_pins_t pin_ctl;
   ppf_pkg::ppf_alt_t alt_req = '0;
   logic [7:0] kwake, adc_in, dd, de, od;
   logic [9:0] grant;
   logic [31:0] seed = 32'h0B0D747F;
   logic [31:0] m [18]; // register model by word index
   int n_errors = 0, num_checks = 0, cyc = 0, i;
   // pull-up on the reset pad, either side may pull it low
   assign reset_pad = (rst_oe_n | rst_out) & ~rst_low;
   ppf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pad), .pin_ctl(pin_ctl), .alt_req(alt_req),
      .pin_level(lvl), .keypad_wake_input(kwake), .analog_channel_input(adc_in),
      .alt_grant(grant), .reset_pin_in(reset_pad), .reset_pin_out(rst_out),
      .reset_pin_oe_n(rst_oe_n), .internal_reset_req(int_req), .startup_reset(startup),
      .ext_irq_n(ext_irq_n), .irq(irq));
   ppf_board board_u (.pclk(pclk), .ctl(pin_ctl), .ext_val(ext_val), .ext_en(ext_en),
      .pad(pad));
   initial forever #20 pclk = ~pclk;
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // implemented bits of each register word but status
   function automatic logic [31:0] wmask(input int k);
      if (k < 10) return {24'h0, ppf_pkg::PORT_MASK[k % 5]};
      if (k == 11) return 32'h7F;
      if (k == 15) return 32'h3F1;
      return (k == 17) ? 32'h3 : 32'hFF;
   endfunction
   // pull-up selection of a port, none on b and e
   function automatic logic [7:0] pullx(input int p);
      return (p == 0) ? m[10][7:0] : (p == 2) ? m[11][7:0] : (p == 3) ? m[12][7:0] : 8'h00;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int k, input logic [31:0] d);
      apb(1'b1, 12'(k * 4), d);
      m[k] = d;
   endtask
   task automatic rd(input int k, input string nm);
      apb(1'b0, 12'(k * 4), 32'h0);
      chk(r, m[k], nm);
      chk(32'(err), 32'h0, "mapped slverr");
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic pulse();
      @(posedge pclk);
      ext_irq_n <= 1'b0;
      @(posedge pclk);
      ext_irq_n <= 1'b1;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      for (i = 0; i < 18; i++) m[i] = 32'h0;
      // refused places first, then reset values
      apb(1'b1, 12'h016, 32'hFF);
      chk(32'(err), 32'h1, "misaligned");
      apb(1'b0, 12'h048, 32'h0);
      chk(32'(err), 32'h1, "unmapped");
      chk(r, 32'h0, "unmapped data");
      for (i = 5; i < 18; i++) rd(i, "reset value");
      for (int n = 0; n < 40; n++) begin
         i = 5 + int'(rnd() % 32'd13);
         if (i == 16) i = 17; // status is write-one-to-clear
         wr(i, rnd() & wmask(i));
         rd(i, "readback");
      end
      $display("done registers");
      // plain port use, no alternate owner
      wr(13, 32'h0);
      wr(14, 32'h0);
      wr(15, 32'h0);
      for (int n = 0; n < 4; n++) begin
         for (int p = 0; p < 13; p++) wr(p, rnd() & wmask(p));
         settle(2);
         for (int p = 0; p < 5; p++) begin
            od = m[p + 5][7:0];
            chk(32'(pin_ctl.oe_n[p]), 32'(od ^ 8'hFF), "oe");
            chk(32'(pin_ctl.out[p] & od), 32'(m[p][7:0] & od), "out");
            chk(32'(pin_ctl.pu[p]), 32'(pullx(p) & (od ^ 8'hFF)), "pu");
         end
      end
      $display("done pins");
      // alternate owners take pins over from an all-output port
      wr(6, 32'hFF);
      wr(8, 32'hFF);
      wr(9, 32'h1F);
      for (int n = 0; n < 8; n++) begin
         wr(15, 32'h301 | (rnd() & 32'hF0));
         wr(14, rnd() & 32'hFF);
         @(posedge pclk);
         alt_req <= 80'({rnd(), rnd(), rnd()});
         settle(3);
         dd = alt_req.drive[ppf_pkg::PD];
         de = alt_req.drive[ppf_pkg::PE] & 8'h1B;
         od = (dd ^ 8'hFF) & {m[15][7:4], 4'hF};
         chk(32'(pin_ctl.oe_n[ppf_pkg::PD]), 32'(od), "oe d");
         chk(32'(pin_ctl.pu[ppf_pkg::PD]), 32'(m[12][7:0] & od), "pu d");
         chk(32'(pin_ctl.out[ppf_pkg::PD] & dd & od), 32'(alt_req.out[3] & dd & od), "d");
         chk(32'(pin_ctl.oe_n[ppf_pkg::PE]), 32'((de ^ 8'h1B) | 8'hE0), "oe e");
         chk(32'(pin_ctl.out[ppf_pkg::PE] & de), 32'(alt_req.out[4] & de), "out e");
         chk(32'(pin_ctl.oe_n[ppf_pkg::PB]), m[14], "oe b");
         chk(32'(adc_in), m[14], "adc");
         chk(32'(grant), m[15], "grant");
         // analog bits read as zero on the data word of port b
         od = m[1][7:0];
         m[1] = 32'(od & ~m[14][7:0]);
         rd(1, "analog read");
         m[1] = 32'(od);
      end
      wr(15, 32'h0);
      $display("done alternate");
      // keyboard subset and the external interrupt
      wr(5, 32'h0);
      wr(13, (rnd() & 32'hFF) | 32'h1);
      wr(17, 32'h3);
      @(posedge pclk);
      ext_val[ppf_pkg::PA] <= 8'(rnd()) | 8'h01;
      settle(5);
      chk(32'(kwake), 32'(ext_val[ppf_pkg::PA]) & m[13], "kbd");
      chk(32'(lvl[ppf_pkg::PA]), 32'(ext_val[ppf_pkg::PA]), "level");
      m[0] = 32'(ext_val[ppf_pkg::PA]);
      rd(0, "pad read");
      apb(1'b1, 12'h040, 32'h3);
      pulse();
      @(posedge pclk);
      ext_val[ppf_pkg::PA] <= 8'h00;
      settle(6);
      chk(32'(irq), 32'h1, "irq");
      m[16] = 32'h3;
      rd(16, "stat");
      apb(1'b1, 12'h040, 32'h3);
      m[16] = 32'h0;
      rd(16, "stat clear");
      chk(32'(irq), 32'h0, "irq clear");
      wr(17, 32'h0);
      pulse();
      settle(6);
      chk(32'(irq), 32'h0, "irq masked");
      m[16] = 32'h1;
      rd(16, "stat masked");
      $display("done interrupts");
      // internal reset drives the pad, a low pad restarts the block
      @(posedge pclk);
      int_req <= 1'b1;
      @(posedge pclk);
      int_req <= 1'b0;
      @(negedge pclk);
      chk(32'(rst_oe_n), 32'h0, "reset drive");
      @(posedge pclk);
      rst_low <= 1'b1;
      settle(4);
      chk(32'(startup), 32'h1, "startup");
      @(posedge pclk);
      rst_low <= 1'b0;
      settle(6);
      for (i = 0; i < 18; i++) m[i] = 32'h0;
      for (i = 5; i < 18; i++) rd(i, "restart");
      $display("done reset");
      complete_run();
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
endmodule
bind ppf_top ppf_top_properties chk_u (.pclk(pclk), .presetn(presetn), .pin_ctl(pin_ctl),
   .alt_req(alt_req), .alt_grant(alt_grant), .reset_pin_in(reset_pin_in),
   .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
   .internal_reset_req(internal_reset_req), .startup_reset(startup_reset));
